// ### rtl/ptimer.sv
// periodic 16-bit timer with compare-match output, APB registers
//
// Design decisions made here: the placing of the registers and register access over APB.
`timescale 1ns/1ns
// Function
// (RULE1) mode field: 00 compare, 01 capture, 10 pwm/single pulse, 11 timer
// (RULE2) compare mode A match: 00 none, 01 low, 10 high, 11 toggle
// (RULE3) pwm modes: 00 inactive, 01 active, 10 pwm, 11 single pulse
// (RULE4) capture: 00 rising, 01 falling, 10 both, 11 disabled
// (RULE5) output level bit: initial level in compare, active level in pwm
// (RULE6) invert bit inverts pin; no effect in timer mode
// (RULE7) capture source: pins when 0, external clock pin when 1
// (RULE8) clear select: 0 clears on P match or overflow, 1 on A match
// (RULE9) overflow clear only when compare P is zero
// (RULE10) clear select ignored in pwm, single pulse and capture
// (RULE11) clear-on-P in compare mode raises both A and P flags
// (RULE12) clear-on-A raises only the A flag, never P
// (RULE13) software must not set compare A to zero in compare mode
// (RULE14) pin changes only on A match, P match leaves it
// (RULE15) enable rising edge returns pin to initial level
// (RULE16) requested level equal to initial level gives no visible change
// (RULE17) timer mode counts like compare mode but releases the pin
// (RULE18) software should stop timer before changing mode
// (RULE19) software changes pin action in pwm only while stopped
// (RULE20) 16-bit up-counter compared against compare A and P
// (RULE21) enable rise zeroes counter; fall holds residual value
// (RULE22) flags set on match cycle, held until software clears
module ptimer
    import ptimer_pkg::*;
#(
    parameter int W = CNT_W
) (
    // clock and reset
    input  wire logic         clk_i,
    input  wire logic         sys_rst_i,
    // apb slave
    input  wire logic         psel_i,
    input  wire logic         penable_i,
    input  wire logic         pwrite_i,
    input  wire logic [7:0]   paddr_i,
    input  wire logic [31:0]  pwdata_i,
    output logic      [31:0]  prdata_o,
    output logic              pready_o,
    output logic              pslverr_o,
    // pins
    input  wire logic         external_clock_pin_i,
    input  wire logic         capture_input_pin_i,
    output logic              timer_output_pin_o,
    output logic              timer_output_pin_oe_o
);
    logic [7:0]   mode_q;
    logic         en_q;
    logic         pause_q;
    logic [2:0]   clk_sel_q;
    logic [W-1:0] cmp_a_q;
    logic [W-1:0] cmp_p_q;
    logic [W-1:0] cnt_q;
    logic         flag_a_q;
    logic         flag_p_q;
    logic         en_prev_q;
    logic         lvl_q;
    logic         pulse_q;
    logic [1:0]   xck_sync_q;
    logic [1:0]   cap_sync_q;
    logic         xck_prev_q;
    logic         cap_prev_q;
    logic [7:0]   div_q;

    op_mode_t     mode;
    logic [1:0]   act;
    logic         init_lvl;
    logic         wr;
    logic         rd;
    logic         en_rise;
    logic         tick;
    logic         match_a;
    logic         match_p;
    logic         clr_cnt;
    logic         cap_src;
    logic         cap_prev_src;
    logic         cap_evt;
    logic         sp_stop;
    logic         sp_start;
    logic         flag_clr_a;
    logic         flag_clr_p;
    logic         pin_lvl;

    assign mode     = op_mode_t'(mode_q[MODE_LSB +: 2]);         // [RULE1]
    assign act      = mode_q[PIN_ACT_LSB +: 2];
    assign init_lvl = mode_q[INIT_LVL_BIT];
    assign wr       = psel_i && penable_i && pwrite_i;
    assign rd       = psel_i && !penable_i && !pwrite_i;
    assign en_rise  = en_q && !en_prev_q;

    // pin inputs pass two flip-flops first
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            xck_sync_q <= 2'h0;
            cap_sync_q <= 2'h0;
            xck_prev_q <= 1'b0;
            cap_prev_q <= 1'b0;
        end else begin
            xck_sync_q <= {xck_sync_q[0], external_clock_pin_i};
            cap_sync_q <= {cap_sync_q[0], capture_input_pin_i};
            xck_prev_q <= xck_sync_q[1];
            cap_prev_q <= cap_sync_q[1];
        end
    end

    // prescaler for internal clock choices
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            div_q <= 8'h00;
        end else begin
            div_q <= div_q + 8'h01;
        end
    end

    always_comb begin
        unique case (clk_sel_q)
            3'h0:        tick = (div_q[1:0] == 2'((DIV_SYS4 - 1) & 3));
            3'h1:        tick = 1'b1;
            3'h2:        tick = (div_q[3:0] == 4'((DIV_H16 - 1) & 15));
            3'h3:        tick = (div_q[5:0] == 6'((DIV_H64 - 1) & 63));
            3'h4, 3'h5:  tick = (div_q == 8'((DIV_SUB - 1) & 255));
            3'h6:        tick = xck_sync_q[1] && !xck_prev_q;
            default:     tick = !xck_sync_q[1] && xck_prev_q;
        endcase
    end

    // full-width comparators, checked on counting ticks only
    assign match_a = en_q && !en_rise && !pause_q && tick && (cnt_q == cmp_a_q);  // [RULE20]
    assign match_p = en_q && !en_rise && !pause_q && tick && (cnt_q == cmp_p_q);  // [RULE20]

    always_comb begin
        unique case (mode)
            MODE_COMPARE, MODE_TIMER: begin
                if (mode_q[CLR_SEL_BIT]) begin                   // [RULE8] [RULE17]
                    clr_cnt = match_a;
                end else begin
                    clr_cnt = match_p && (cmp_p_q != '0);        // [RULE9]
                end
            end
            // clear select is ignored here
            MODE_CAPTURE: clr_cnt = match_p && (cmp_p_q != '0);  // [RULE10]
            MODE_PWM:     clr_cnt = (act != ACT_TOG) && match_p && (cmp_p_q != '0);  // [RULE10]
        endcase
    end

    // capture trigger
    assign cap_src      = mode_q[CAP_SRC_BIT] ? xck_sync_q[1] : cap_sync_q[1];  // [RULE7]
    assign cap_prev_src = mode_q[CAP_SRC_BIT] ? xck_prev_q : cap_prev_q;
    always_comb begin
        cap_evt = 1'b0;
        if (mode == MODE_CAPTURE && en_q) begin
            unique case (act)                                    // [RULE4]
                2'h0:    cap_evt = cap_src && !cap_prev_src;
                2'h1:    cap_evt = !cap_src && cap_prev_src;
                2'h2:    cap_evt = cap_src != cap_prev_src;
                default: cap_evt = 1'b0;
            endcase
        end
    end

    // single pulse: A match stops it, external edge starts it
    assign sp_stop  = mode == MODE_PWM && act == ACT_TOG && match_a;
    assign sp_start = mode == MODE_PWM && act == ACT_TOG && !en_q
                      && xck_sync_q[1] && !xck_prev_q;

    // counter
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cnt_q <= '0;
        end else if (en_rise) begin
            cnt_q <= '0;                                         // [RULE21]
        end else if (en_q && !pause_q && tick) begin
            cnt_q <= clr_cnt ? '0 : cnt_q + 1'b1;                // [RULE9]
        end
    end

    // enable history for the rising-edge detect
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            en_prev_q <= 1'b0;
        end else begin
            en_prev_q <= en_q;
        end
    end

    assign flag_clr_a = wr && paddr_i == OFF_FLAGS && pwdata_i[FLAG_A_BIT];
    assign flag_clr_p = wr && paddr_i == OFF_FLAGS && pwdata_i[FLAG_P_BIT];

    // sticky flags, write one clears, a new match wins over the clear
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            flag_a_q <= 1'b0;
            flag_p_q <= 1'b0;
        end else begin
            if (match_a || cap_evt) begin
                flag_a_q <= 1'b1;                                // [RULE22] [RULE11]
            end else if (flag_clr_a) begin
                flag_a_q <= 1'b0;
            end
            // no p flag when the counter clears on A
            if (match_p && !((mode == MODE_COMPARE || mode == MODE_TIMER)
                             && mode_q[CLR_SEL_BIT])) begin
                flag_p_q <= 1'b1;                                // [RULE12] [RULE22]
            end else if (flag_clr_p) begin
                flag_p_q <= 1'b0;
            end
        end
    end

    // compare-mode output level before polarity
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            lvl_q <= 1'b0;
        end else if (en_rise || mode != MODE_COMPARE && !en_q) begin
            lvl_q <= init_lvl;                                   // [RULE15] [RULE5]
        end else if (mode == MODE_COMPARE && match_a) begin     // [RULE14]
            unique case (act)                                    // [RULE2]
                ACT_NONE: lvl_q <= lvl_q;
                ACT_LOW:  lvl_q <= 1'b0;                         // [RULE16]
                ACT_HIGH: lvl_q <= 1'b1;                         // [RULE16]
                ACT_TOG:  lvl_q <= !lvl_q;
            endcase
        end
    end

    // pwm active phase: counter below compare A, or the whole period when compare A is at or above a nonzero compare P
    always_comb begin
        pin_lvl = lvl_q;
        if (mode == MODE_PWM) begin
            unique case (act)                                    // [RULE3]
                2'h0:    pin_lvl = !init_lvl;
                2'h1:    pin_lvl = init_lvl;
                default: pin_lvl = pulse_q ? init_lvl : !init_lvl;  // [RULE5]
            endcase
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pulse_q <= 1'b0;
        end else if (act == ACT_TOG) begin
            pulse_q <= en_q && !sp_stop;
        end else begin
            pulse_q <= en_q && (cnt_q < cmp_a_q || cmp_a_q >= cmp_p_q && cmp_p_q != '0);
        end
    end

    // pin driver; timer mode releases the pin
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            timer_output_pin_o    <= 1'b0;
            timer_output_pin_oe_o <= 1'b0;
        end else begin
            timer_output_pin_o    <= pin_lvl ^ mode_q[INVERT_BIT];   // [RULE6]
            timer_output_pin_oe_o <= mode == MODE_COMPARE || mode == MODE_PWM;  // [RULE17]
        end
    end

    // compare A; a capture wins over a software write
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cmp_a_q <= CMP_RESET;
        end else if (cap_evt) begin
            cmp_a_q <= cnt_q;
        end else if (wr && paddr_i == OFF_CMP_A) begin
            cmp_a_q <= pwdata_i[W-1:0];
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cmp_p_q <= CMP_RESET;
        end else if (wr && paddr_i == OFF_CMP_P) begin
            cmp_p_q <= pwdata_i[W-1:0];
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            mode_q <= MODE_RESET;
        end else if (wr && paddr_i == OFF_MODE) begin
            mode_q <= pwdata_i[7:0];
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pause_q   <= 1'b0;
            clk_sel_q <= 3'h0;
        end else if (wr && paddr_i == OFF_CTRL) begin
            pause_q   <= pwdata_i[CTRL_PAUSE_BIT];
            clk_sel_q <= pwdata_i[CTRL_CLK_LSB +: 3];
        end
    end

    // single pulse may flip enable behind software's back
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            en_q <= 1'b0;
        end else if (sp_stop) begin
            en_q <= 1'b0;
        end else if (sp_start) begin
            en_q <= 1'b1;
        end else if (wr && paddr_i == OFF_CTRL) begin
            en_q <= pwdata_i[CTRL_EN_BIT];
        end
    end

    // apb answer: no wait state, ready registered from the setup phase
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
        end else begin
            pready_o  <= psel_i && !penable_i;
            pslverr_o <= psel_i && !penable_i && !(paddr_i inside
                         {OFF_CTRL, OFF_MODE, OFF_CMP_A, OFF_CMP_P, OFF_COUNT, OFF_FLAGS});
        end
    end

    // read data latched in setup, held until the next read
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            prdata_o <= 32'h0000_0000;
        end else if (rd) begin
            unique case (paddr_i)
                OFF_CTRL:  prdata_o <= {24'h0, 1'b0, clk_sel_q, 2'h0, pause_q, en_q};
                OFF_MODE:  prdata_o <= {24'h0, mode_q};
                OFF_CMP_A: prdata_o <= {16'h0, cmp_a_q};
                OFF_CMP_P: prdata_o <= {16'h0, cmp_p_q};
                OFF_COUNT: prdata_o <= {16'h0, cnt_q};
                OFF_FLAGS: prdata_o <= {30'h0, flag_p_q, flag_a_q};
                default:   prdata_o <= 32'h0000_0000;
            endcase
        end
    end
endmodule // ptimer

// ### rtl/ptimer_pkg.sv
// constants for the periodic timer block
package ptimer_pkg;
    localparam int          CNT_W          = 16;
    // register byte offsets
    localparam logic [7:0]  OFF_CTRL       = 8'h00;
    localparam logic [7:0]  OFF_MODE       = 8'h04;
    localparam logic [7:0]  OFF_CMP_A      = 8'h08;
    localparam logic [7:0]  OFF_CMP_P      = 8'h0C;
    localparam logic [7:0]  OFF_COUNT      = 8'h10;
    localparam logic [7:0]  OFF_FLAGS      = 8'h14;
    // control register fields
    localparam int          CTRL_EN_BIT    = 0;
    localparam int          CTRL_PAUSE_BIT = 1;
    localparam int          CTRL_CLK_LSB   = 4;
    // mode register fields
    localparam int          MODE_LSB       = 6;
    localparam int          PIN_ACT_LSB    = 4;
    localparam int          INIT_LVL_BIT   = 3;
    localparam int          INVERT_BIT     = 2;
    localparam int          CAP_SRC_BIT    = 1;
    localparam int          CLR_SEL_BIT    = 0;
    // flag register fields
    localparam int          FLAG_A_BIT     = 0;
    localparam int          FLAG_P_BIT     = 1;
    localparam logic [7:0]  MODE_RESET     = 8'h00;
    localparam logic [15:0] CMP_RESET      = 16'h0000;
    // timer clock prescale ratios
    localparam int          DIV_SYS4       = 4;
    localparam int          DIV_H16        = 16;
    localparam int          DIV_H64        = 64;
    localparam int          DIV_SUB        = 256;

    typedef enum logic [1:0] {
        MODE_COMPARE,
        MODE_CAPTURE,
        MODE_PWM,
        MODE_TIMER
    } op_mode_t;

    // pin-action codes in compare mode
    localparam logic [1:0]  ACT_NONE = 2'h0;
    localparam logic [1:0]  ACT_LOW  = 2'h1;
    localparam logic [1:0]  ACT_HIGH = 2'h2;
    localparam logic [1:0]  ACT_TOG  = 2'h3;
endpackage

// ### sim/ptimer_checker.sv
// port assertions for the periodic timer
`timescale 1ns/1ns
module ptimer_checker
    import ptimer_pkg::*;
#(
    parameter int W = CNT_W
) (
    // clock and reset
    input wire logic        clk_i,
    input wire logic        sys_rst_i,
    // apb
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [7:0]  paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    // pins
    input wire logic        external_clock_pin_i,
    input wire logic        capture_input_pin_i,
    input wire logic        timer_output_pin_o,
    input wire logic        timer_output_pin_oe_o
);
    logic [7:0] mode_q;
    logic       en_q;
    logic       rd_acc;
    assign rd_acc = psel_i && penable_i && pready_o && !pwrite_i;
    // software view only; a single-pulse self-stop is not tracked
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            mode_q <= MODE_RESET;
            en_q   <= 1'b0;
        end else if (psel_i && penable_i && pwrite_i) begin
            if (paddr_i == OFF_MODE) mode_q <= pwdata_i[7:0];
            if (paddr_i == OFF_CTRL) en_q <= pwdata_i[CTRL_EN_BIT];
        end
    end
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (sys_rst_i);
    a_ready_access: assert property (psel_i && penable_i |-> pready_o)
        else $error("no ready in access cycle");
    a_error_unmapped: assert property (pready_o && paddr_i[1:0] == 2'h0 |-> pslverr_o == (paddr_i > OFF_FLAGS))
        else $error("error response wrong");
    a_mode_readback: assert property (rd_acc && paddr_i == OFF_MODE |-> prdata_o == {24'h0, mode_q})
        else $error("mode readback differs");
    a_count_width: assert property (rd_acc && paddr_i == OFF_COUNT |-> prdata_o[31:W] == '0)
        else $error("count wider than counter");
    a_oe_compare: assert property ((mode_q[7:6] == 2'h0) [*4] |-> timer_output_pin_oe_o)
        else $error("pin not driven in compare mode");
    a_oe_timer: assert property ((mode_q[7:6] == 2'h3) [*4] |-> !timer_output_pin_oe_o)
        else $error("pin driven in timer mode");
    a_pin_reinit: assert property ($rose(en_q) && mode_q[7:6] == 2'h0 |->
        ##[1:3] timer_output_pin_o == (mode_q[INIT_LVL_BIT] ^ mode_q[INVERT_BIT]))
        else $error("pin not back at initial level");
    a_pin_hold: assert property ((en_q && mode_q[7:4] == 4'h0 && $stable(mode_q)) [*5] |->
        $stable(timer_output_pin_o))
        else $error("pin moved with no action set");
endmodule // ptimer_checker
bind ptimer ptimer_checker #(.W(W)) ptimer_checker_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .external_clock_pin_i(external_clock_pin_i), .capture_input_pin_i(capture_input_pin_i),
    .timer_output_pin_o(timer_output_pin_o), .timer_output_pin_oe_o(timer_output_pin_oe_o));

// ### sim/ptimer_pin_model.sv
// pin-side model driving the capture and external clock pins
`timescale 1ns/1ns
module ptimer_pin_model (
    // commands from the bench
    input  wire logic cap_cmd_i,
    input  wire logic ext_cmd_i,
    // pins into the timer
    output wire logic cap_pin_o,
    output wire logic ext_pin_o
);
    // commands already change on the rising edge; pins follow at once
    assign cap_pin_o = cap_cmd_i;
    assign ext_pin_o = ext_cmd_i;
endmodule // ptimer_pin_model

// ### sim/tb_periodic_timer_compare_mode_control.sv
// self-checking bench for the periodic timer
`timescale 1ns/1ns
module tb_periodic_timer_compare_mode_control;
    import ptimer_pkg::*;
    logic        clk_i = 1'b0, sys_rst_i = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        cap_cmd = 1'b0, ext_cmd = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd, c1;
    logic        pready, pslverr, pin, oe, cap_pin, ext_pin, last_err;
    int          err_count = 0, cmp_count = 0;
    always #5 clk_i = ~clk_i;
    ptimer ptimer_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .external_clock_pin_i(ext_pin), .capture_input_pin_i(cap_pin),
        .timer_output_pin_o(pin), .timer_output_pin_oe_o(oe));
    ptimer_pin_model ptimer_pin_model_inst (.cap_cmd_i(cap_cmd), .ext_cmd_i(ext_cmd),
        .cap_pin_o(cap_pin), .ext_pin_o(ext_pin));
    task test_done;
        $display("compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH %s expected %0h seen %0h", n, e, g);
        end
    endtask
    // idle edge first, so psel never gets two assignments in one step
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge clk_i);
        penable <= 1'b1;
        do begin @(posedge clk_i); n++; end while (pready !== 1'b1);
        rd = prdata;
        last_err = pslverr;
        {psel, penable} <= 2'h0;
        chk("pready_wait", 32'h1, 32'(n));
    endtask
    task wait_flag(input logic [31:0] m);
        int n;
        n = 0;
        do begin apb(1'b0, OFF_FLAGS, 32'h0); n++; end while ((rd & m) !== m && n < 100);
        chk("flag_wait", m, rd & m);
    endtask
    task start(input logic [7:0] md, input logic [15:0] a, input logic [15:0] p);
        apb(1'b1, OFF_CTRL, 32'h0);
        apb(1'b1, OFF_MODE, {24'h0, md});
        apb(1'b1, OFF_CMP_A, {16'h0, a});
        apb(1'b1, OFF_CMP_P, {16'h0, p});
        apb(1'b1, OFF_FLAGS, 32'h3);
        apb(1'b1, OFF_CTRL, 32'h11);
    endtask
    task t_regs;
        apb(1'b0, OFF_MODE, 32'h0);
        chk("mode_reset", 32'h0, rd);
        apb(1'b1, OFF_MODE, 32'hA5);
        apb(1'b0, OFF_MODE, 32'h0);
        chk("mode_rw", 32'hA5, rd);
        apb(1'b0, 8'h40, 32'h0);
        chk("unmapped_err", 32'h1, 32'(last_err));
        $display("t_regs done");
    endtask
    task t_pin_actions;
        logic [1:0] act;
        logic       ini, inv, lvl;
        for (int c = 0; c < 16; c++) begin
            {act, ini, inv} = c[3:0];
            start({2'h0, act, ini, inv, 2'h0}, 16'h28, 16'h0);
            repeat (3) @(posedge clk_i);
            chk("pin_initial", 32'(ini ^ inv), 32'(pin));
            wait_flag(32'h1);
            repeat (3) @(posedge clk_i);
            lvl = (act == ACT_NONE) ? ini : (act == ACT_TOG) ? ~ini : act[1];
            chk("pin_action", 32'(lvl ^ inv), 32'(pin));
            chk("pin_driven", 32'h1, 32'(oe));
        end
        $display("t_pin_actions done");
    endtask
    task t_clear;
        for (int m = 0; m < 2; m++) begin
            start(m ? 8'hC0 : 8'h00, 16'h0A, 16'h14);
            wait_flag(32'h2);
            chk("flags_both", 32'h3, rd);
            apb(1'b0, OFF_COUNT, 32'h0);
            chk("count_le_p", 32'h1, 32'(rd <= 32'h14));
            chk("pin_released", 32'(m == 0), 32'(oe));
            start(m ? 8'hC1 : 8'h01, 16'h0A, 16'h03);
            repeat (40) @(posedge clk_i);
            apb(1'b0, OFF_FLAGS, 32'h0);
            chk("flag_a_only", 32'h1, rd);
            apb(1'b0, OFF_COUNT, 32'h0);
            chk("count_le_a", 32'h1, 32'(rd <= 32'h0A));
        end
        $display("t_clear done");
    endtask
    task t_hold;
        start(8'h00, 16'h1F4, 16'h0);
        repeat (100) @(posedge clk_i);
        apb(1'b1, OFF_CTRL, 32'h0);
        apb(1'b0, OFF_COUNT, 32'h0);
        c1 = rd;
        repeat (10) @(posedge clk_i);
        apb(1'b0, OFF_COUNT, 32'h0);
        chk("count_held", c1, rd);
        apb(1'b1, OFF_CTRL, 32'h11);
        apb(1'b0, OFF_COUNT, 32'h0);
        chk("count_restart", 32'h1, 32'(rd < 32'h8 && c1 > 32'h40));
        apb(1'b1, OFF_CTRL, 32'h13);
        apb(1'b0, OFF_COUNT, 32'h0);
        c1 = rd;
        repeat (10) @(posedge clk_i);
        apb(1'b0, OFF_COUNT, 32'h0);
        chk("count_paused", c1, rd);
        $display("t_hold done");
    endtask
    task t_pwm;
        int hi;
        hi = 0;
        start(8'h88, 16'h4, 16'h8);
        repeat (3) @(posedge clk_i);
        chk("pwm_inactive", 32'h0, 32'(pin));
        start(8'h9C, 16'h4, 16'h8);
        repeat (3) @(posedge clk_i);
        chk("pwm_active_inv", 32'h0, 32'(pin));
        start(8'hA9, 16'h4, 16'h8);
        wait_flag(32'h2);
        for (int i = 0; i < 20; i++) begin
            @(posedge clk_i);
            hi += pin;
        end
        chk("pwm_toggles", 32'h1, 32'(hi > 0 && hi < 20));
        $display("t_pwm done");
    endtask
    task t_capture;
        start(8'h40, 16'h0, 16'h0);
        repeat (30) @(posedge clk_i);
        cap_cmd <= 1'b1;
        repeat (8) @(posedge clk_i);
        apb(1'b0, OFF_CMP_A, 32'h0);
        chk("capture_pin", 32'h1, 32'(rd != 32'h0 && rd < 32'h64));
        cap_cmd <= 1'b0;
        start(8'h42, 16'h0, 16'h0);
        cap_cmd <= 1'b1;
        repeat (8) @(posedge clk_i);
        apb(1'b0, OFF_CMP_A, 32'h0);
        chk("capture_ignored", 32'h0, rd);
        ext_cmd <= 1'b1;
        repeat (8) @(posedge clk_i);
        apb(1'b0, OFF_CMP_A, 32'h0);
        chk("capture_ext", 32'h1, 32'(rd != 32'h0));
        start(8'h50, 16'h0, 16'h0);
        repeat (20) @(posedge clk_i);
        cap_cmd <= 1'b0;
        repeat (8) @(posedge clk_i);
        apb(1'b0, OFF_CMP_A, 32'h0);
        chk("capture_fall", 32'h1, 32'(rd != 32'h0));
        start(8'h70, 16'h0, 16'h0);
        cap_cmd <= 1'b1;
        repeat (8) @(posedge clk_i);
        cap_cmd <= 1'b0;
        repeat (8) @(posedge clk_i);
        apb(1'b0, OFF_CMP_A, 32'h0);
        chk("capture_off", 32'h0, rd);
        $display("t_capture done");
    endtask
    initial begin
        repeat (2) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        t_regs;
        t_pin_actions;
        t_clear;
        t_hold;
        t_pwm;
        t_capture;
        test_done;
    end
    // the whole run needs well under a third of this
    initial begin
        repeat (20000) @(posedge clk_i);
        err_count++;
        test_done;
    end
endmodule // tb_periodic_timer_compare_mode_control
